// [snm_mem_array.sv]
// Byte array held in flip-flops, one write port and one combinational read port
`timescale 1ns/1ps
`default_nettype none
module snm_mem_array import snm_pkg::*; (
  snm_mem_if.array mem // Array side of the carrier
);
  // No reset: the array models nonvolatile storage and keeps its bytes
  snm_byte_type cells [0:`SNM_MEM_DEPTH-1];

  always_ff @(posedge mem.clk) begin
    if (mem.ce && mem.we) begin
      cells[mem.waddr] <= mem.wdata;
    end
  end

  assign mem.rdata = cells[mem.raddr];
endmodule : snm_mem_array
`default_nettype wire

// [snm_mem_if.sv]
// Carrier between the controller and its byte array
`timescale 1ns/1ps
`default_nettype none
interface snm_mem_if import snm_pkg::*; (
  input wire logic clk // Array clock
);
  logic ce;
  logic we;
  snm_addr_type waddr;
  snm_byte_type wdata;
  snm_addr_type raddr;
  snm_byte_type rdata;
  modport ctrl (input clk, output ce, output we, output waddr, output wdata, output raddr, input rdata);
  modport array (input clk, input ce, input we, input waddr, input wdata, input raddr, output rdata);
endinterface : snm_mem_if
`default_nettype wire

// [snm_pkg.sv]
// Types shared by the protect controller and its array
`default_nettype none
`include "snm_regs.svh"
package snm_pkg;
  typedef logic [`SNM_ADDR_W-1:0] snm_addr_type;
  typedef logic [7:0] snm_byte_type;
  typedef enum logic [3:0] {
    SNM_IDLE = 4'b0000,
    SNM_OPCODE = 4'b0001,
    SNM_ADDR_HI = 4'b0010,
    SNM_ADDR_LO = 4'b0011,
    SNM_STATUS_RD = 4'b0100,
    SNM_STATUS_WR = 4'b0101,
    SNM_READ = 4'b0110,
    SNM_WRITE = 4'b0111,
    SNM_IGNORE = 4'b1000
  } snm_state_type;
endpackage : snm_pkg
`default_nettype wire

// [snm_protect_ctrl.sv]
// SPI slave command logic with status register, write latch and block protection
// Operation
// R1 - Status bits 0 and 4-6 ignore writes and read as zero.
// R2 - Status bit 1 shows the write latch; zero after power-up.
// R3 - Status write data never touches the latch bit; only opcodes set or clear it.
// R4 - Block protect bits 2 and 3 are writable and kept as nonvolatile.
// R5 - Protect pair: none, 600h-7FFh, 400h-7FFh, or whole array.
// R6 - Bit 7 arms the protect pin; armed and pin low blocks status writes.
// R7 - The protect pin never blocks array writes.
// R8 - Status read command returns the current status byte.
// R9 - Status write needs the latch set, updates bits, then clears the latch.
// R10 - Master holds the protect pin high before a status write.
// R11 - Two address bytes follow read or write; only the low 11 bits count.
// R12 - Write address increments per byte and wraps 7FFh to 000h.
// R13 - Each byte commits on its eighth bit; a partial byte is dropped.
// R14 - Data MSB first; chip select rising ends the write.
// R15 - Reaching a protected address stops incrementing and drops further bytes.
// R16 - Read data driven on the next eight clocks MSB first; input ignored.
// R17 - Read address increments per byte and wraps 7FFh to 000h.
// R18 - Chip select rising ends a read and floats the output.
// R19 - Pause low with clock low suspends; pause high resumes in place.
// R20 - Master changes pause only while the clock is low.
// R21 - Set latch 06h, clear latch 04h, status read 05h, first byte.
// R22 - Status write 01h, memory read 03h, memory write 02h.
// R23 - Latch clears at chip select rising after clear, status write or write.
// R24 - Unknown opcode: ignore input until next select, keep output floating.
`timescale 1ns/1ps
`default_nettype none
`include "snm_regs.svh"
module snm_protect_ctrl import snm_pkg::*; (
  input wire logic clk, // System clock, 40 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic cs_n, // Chip select pin, active low
  input wire logic sck, // Serial clock pin
  input wire logic si, // Serial data in pin
  input wire logic pause_pin_n, // Pause pin, active low
  input wire logic write_protect_pin_n, // Write protect pin, active low
  output logic so_data, // Serial data out level
  output logic so_oe_n // Serial out enable, low while driving
);

  localparam logic [`SNM_PIN_COUNT-1:0] PIN_IDLE = `SNM_PIN_IDLE;

  logic [`SNM_PIN_COUNT-1:0] pin_raw;
  logic [`SNM_PIN_COUNT-1:0] sync_a;
  logic [`SNM_PIN_COUNT-1:0] sync_b;
  logic sck_prev;
  logic cs_prev;
  logic cs_s;
  logic sck_s;
  logic si_s;
  logic paused;
  logic wp_low;
  logic selected;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic byte_done;
  logic [2:0] bit_cnt;
  snm_byte_type rx;
  snm_byte_type rx_next;
  snm_byte_type tx;
  snm_byte_type status_byte;
  snm_state_type state;
  snm_addr_type addr;
  logic op_write;
  logic write_latch;
  logic clear_pending;
  logic prot_pin_en;
  logic bp_hi;
  logic bp_lo;
  logic status_wr_ok;
  logic write_stop;
  logic addr_locked;
  logic drive;
  logic wr_en;
  snm_addr_type wr_addr;
  snm_byte_type wr_data;
  snm_addr_type rd_index;

  snm_mem_if u_mem_bus (
    .clk(clk)
  );

  snm_mem_array u_array (
    .mem(u_mem_bus)
  );

  // Pins come from the master's domain; two stages before any logic looks
  assign pin_raw = {write_protect_pin_n, pause_pin_n, si, sck, cs_n};

  generate
    for (genvar i = 0; i < `SNM_PIN_COUNT; i++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sync_a[i] <= PIN_IDLE[i];
          sync_b[i] <= PIN_IDLE[i];
        end else if (ce) begin
          sync_a[i] <= pin_raw[i];
          sync_b[i] <= sync_a[i];
        end
      end
    end
  endgenerate

  assign cs_s = sync_b[`SNM_PIN_CS];
  assign sck_s = sync_b[`SNM_PIN_SCK];
  assign si_s = sync_b[`SNM_PIN_SI];
  assign paused = ~sync_b[`SNM_PIN_PAUSE]; // R19
  assign wp_low = ~sync_b[`SNM_PIN_WP];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_prev <= PIN_IDLE[`SNM_PIN_SCK];
      cs_prev <= PIN_IDLE[`SNM_PIN_CS];
    end else if (ce) begin
      sck_prev <= sck_s;
      cs_prev <= cs_s;
    end
  end

  // Clock edges keep being tracked while paused so none is replayed on resume
  assign selected = ~cs_s & ~cs_prev;
  assign cs_fall = ~cs_s & cs_prev;
  assign cs_rise = cs_s & ~cs_prev;
  assign sck_rise = selected & ~paused & sck_s & ~sck_prev; // R19
  assign sck_fall = selected & ~paused & ~sck_s & sck_prev;
  assign rx_next = {rx[6:0], si_s}; // R14
  assign byte_done = sck_rise & (bit_cnt == `SNM_BIT_LAST); // R13

  // Unwritable bits come from the reset constant and can never be set
  always_comb begin
    status_byte = `SNM_STATUS_RESET; // R1
    status_byte[`SNM_BIT_LATCH] = write_latch; // R2
    status_byte[`SNM_BIT_BP_LO] = bp_lo;
    status_byte[`SNM_BIT_BP_HI] = bp_hi;
    status_byte[`SNM_BIT_PPE] = prot_pin_en;
  end

  // Protect pin only gates the status register, never the array
  assign status_wr_ok = write_latch & ~(prot_pin_en & wp_low); // R6

  // Protected range is judged on the byte address about to be written
  always_comb begin
    case ({bp_hi, bp_lo})
      `SNM_BP_NONE: addr_locked = 1'b0; // R5
      `SNM_BP_QUARTER: addr_locked = (addr >= `SNM_PROT_QUARTER); // R5
      `SNM_BP_HALF: addr_locked = (addr >= `SNM_PROT_HALF); // R5
      default: addr_locked = 1'b1; // R5
    endcase
  end

  // Bit count restarts only on a falling select, so a partial byte never completes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= `SNM_BIT_FIRST;
      rx <= 8'h00;
    end else if (ce) begin
      if (cs_fall) begin
        bit_cnt <= `SNM_BIT_FIRST;
      end else if (sck_rise) begin
        bit_cnt <= bit_cnt + `SNM_BIT_ONE;
        rx <= rx_next;
      end
    end
  end

  // Frame sequencer; a rising select ends any command at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= SNM_IDLE;
      op_write <= 1'b0;
    end else if (ce) begin
      if (cs_rise) begin
        state <= SNM_IDLE; // R14 R18
      end else if (cs_fall) begin
        state <= SNM_OPCODE;
      end else if (byte_done) begin
        case (state)
          SNM_OPCODE: begin
            case (rx_next)
              `SNM_OP_STATUS_READ: state <= SNM_STATUS_RD; // R21
              `SNM_OP_STATUS_WRITE: state <= SNM_STATUS_WR; // R22
              `SNM_OP_MEM_READ: begin
                state <= SNM_ADDR_HI; // R22
                op_write <= 1'b0;
              end
              `SNM_OP_MEM_WRITE: begin
                state <= SNM_ADDR_HI; // R22
                op_write <= 1'b1;
              end
              default: state <= SNM_IGNORE; // R24
            endcase
          end
          SNM_ADDR_HI: state <= SNM_ADDR_LO;
          SNM_ADDR_LO: state <= op_write ? SNM_WRITE : SNM_READ;
          SNM_STATUS_WR: state <= SNM_IGNORE;
          default: state <= state;
        endcase
      end
    end
  end

  // Address moves only on a completed byte; a locked burst parks on its first protected byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr <= '0;
    end else if (ce && byte_done) begin
      case (state)
        SNM_ADDR_HI: addr[`SNM_ADDR_W-1:8] <= rx_next[`SNM_ADDR_HI_MSB:0]; // R11
        SNM_ADDR_LO: addr[7:0] <= rx_next; // R11
        SNM_READ: addr <= addr + `SNM_ADDR_ONE; // R17
        SNM_WRITE: begin
          if (!write_stop && !addr_locked) begin
            addr <= addr + `SNM_ADDR_ONE; // R12
          end
        end
        default: addr <= addr;
      endcase
    end
  end

  // Latch: set by its command, cleared only when the select ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_latch <= 1'b0; // R2
      clear_pending <= 1'b0;
    end else if (ce) begin
      if (cs_rise) begin
        if (clear_pending) begin
          write_latch <= 1'b0; // R23 R9
        end
        clear_pending <= 1'b0;
      end else if (cs_fall) begin
        clear_pending <= 1'b0;
      end else if (byte_done && state == SNM_OPCODE) begin
        if (rx_next == `SNM_OP_SET_LATCH) begin
          write_latch <= 1'b1; // R3 R21
        end
        if (rx_next == `SNM_OP_CLEAR_LATCH || rx_next == `SNM_OP_STATUS_WRITE ||
            rx_next == `SNM_OP_MEM_WRITE) begin
          clear_pending <= 1'b1; // R23
        end
      end
    end
  end

  // Reset stands for the factory state of the nonvolatile bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prot_pin_en <= 1'b0;
      bp_hi <= 1'b0;
      bp_lo <= 1'b0;
    end else if (ce && byte_done && state == SNM_STATUS_WR && status_wr_ok) begin
      prot_pin_en <= rx_next[`SNM_BIT_PPE]; // R6 R9
      bp_hi <= rx_next[`SNM_BIT_BP_HI]; // R4
      bp_lo <= rx_next[`SNM_BIT_BP_LO]; // R4
    end
  end

  // Sticky for the rest of the frame: later bytes stay lost even where the address allows them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_stop <= 1'b0;
    end else if (ce) begin
      if (cs_fall) begin
        write_stop <= 1'b0;
      end else if (byte_done && state == SNM_WRITE && addr_locked) begin
        write_stop <= 1'b1; // R15
      end
    end
  end

  // One write per completed byte; the latch and protect pair decide, not the pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_en <= 1'b0;
      wr_addr <= '0;
      wr_data <= 8'h00;
    end else if (ce) begin
      wr_en <= byte_done && state == SNM_WRITE && write_latch && !write_stop && !addr_locked; // R7 R13 R15
      wr_addr <= addr;
      wr_data <= rx_next;
    end
  end

  assign u_mem_bus.ce = ce;
  assign u_mem_bus.we = wr_en;
  assign u_mem_bus.waddr = wr_addr;
  assign u_mem_bus.wdata = wr_data;
  // Next read byte: the fresh start address, or the one after the current
  always_comb begin
    if (state == SNM_ADDR_LO) begin
      rd_index = {addr[`SNM_ADDR_W-1:8], rx_next}; // R17
    end else begin
      rd_index = addr + `SNM_ADDR_ONE; // R17
    end
  end

  assign u_mem_bus.raddr = rd_index;

  // Output loads on the eighth rise and shifts on each fall, so the MSB
  // leads in both clock modes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx <= 8'h00;
      so_data <= 1'b0;
    end else if (ce) begin
      if (byte_done && ((state == SNM_OPCODE && rx_next == `SNM_OP_STATUS_READ) || state == SNM_STATUS_RD)) begin
        tx <= status_byte; // R8
      end else if (byte_done && ((state == SNM_ADDR_LO && !op_write) || state == SNM_READ)) begin
        tx <= u_mem_bus.rdata; // R16
      end else if (sck_fall) begin
        so_data <= tx[7]; // R16
        tx <= {tx[6:0], 1'b0};
      end
    end
  end

  // Drive begins at the first fall of a data phase, when the first bit is already set up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive <= 1'b0;
    end else if (ce) begin
      if (cs_rise || cs_fall) begin
        drive <= 1'b0; // R18
      end else if (sck_fall && (state == SNM_STATUS_RD || state == SNM_READ)) begin
        drive <= 1'b1;
      end
    end
  end

  // Output floats while paused or deselected, and in every other state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      so_oe_n <= 1'b1;
    end else if (ce) begin
      so_oe_n <= ~(drive & ~paused & ~cs_s); // R18 R19 R24
    end
  end

endmodule : snm_protect_ctrl
`default_nettype wire

// [snm_protect_ctrl_asserts.sv]
// Port-level timing checks of the protect controller serial output
`timescale 1ns/1ps
`default_nettype none
module snm_protect_asserts (
  input wire logic clk, // System clock
  input wire logic rst, // Reset, active high
  input wire logic ce, // Clock enable
  input wire logic cs_n, // Chip select pin
  input wire logic sck, // Serial clock pin
  input wire logic si, // Serial data in
  input wire logic pause_pin_n, // Pause pin
  input wire logic write_protect_pin_n, // Protect pin
  input wire logic so_data, // Serial out level
  input wire logic so_oe_n // Serial out enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_reset_float;
    $fell(rst) |-> so_oe_n && !so_data;
  endproperty
  a_reset_float: assert property (p_reset_float)
    else $error("output active after reset");
  property p_cs_float;
    $rose(cs_n) |-> ##[1:6] so_oe_n;
  endproperty
  a_cs_float: assert property (p_cs_float)
    else $error("output not floated after deselect");
  property p_drive_cause;
    $fell(so_oe_n) |-> !cs_n && pause_pin_n && !$past(cs_n, 3);
  endproperty
  a_drive_cause: assert property (p_drive_cause)
    else $error("output driven while not selected");
  property p_pause_float;
    !pause_pin_n [*6] |-> so_oe_n;
  endproperty
  a_pause_float: assert property (p_pause_float)
    else $error("output driven during pause");
  property p_rise_cause;
    $rose(so_oe_n) |-> cs_n || !pause_pin_n;
  endproperty
  a_rise_cause: assert property (p_rise_cause)
    else $error("output floated without cause");
  property p_data_cause;
    $changed(so_data) && !so_oe_n && !$past(so_oe_n) |-> !$past(sck, 2);
  endproperty
  a_data_cause: assert property (p_data_cause)
    else $error("output changed away from a clock fall");
  property p_data_hold;
    $rose(sck) && !cs_n |=> $stable(so_data) [*3];
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("output moved in clock high phase");
  property p_oe_hold;
    $fell(so_oe_n) |=> !so_oe_n [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("output enable glitched");
  property p_freeze;
    !ce |=> $stable(so_oe_n) && $stable(so_data);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("output moved while clock enable low");
endmodule : snm_protect_asserts
bind snm_protect_ctrl snm_protect_asserts chk_i (.clk, .rst, .ce, .cs_n, .sck, .si, .pause_pin_n,
  .write_protect_pin_n, .so_data, .so_oe_n);
`default_nettype wire

// [snm_regs.svh]
// Opcodes, status field positions, address limits and pin layout of the protect controller
`ifndef SNM_REGS_SVH
`define SNM_REGS_SVH

`define SNM_OP_SET_LATCH 8'h06
`define SNM_OP_CLEAR_LATCH 8'h04
`define SNM_OP_STATUS_READ 8'h05
`define SNM_OP_STATUS_WRITE 8'h01
`define SNM_OP_MEM_READ 8'h03
`define SNM_OP_MEM_WRITE 8'h02

`define SNM_STATUS_RESET 8'h00
`define SNM_BIT_LATCH 1
`define SNM_BIT_BP_LO 2
`define SNM_BIT_BP_HI 3
`define SNM_BIT_PPE 7

`define SNM_ADDR_W 11
`define SNM_ADDR_HI_MSB 2
`define SNM_MEM_DEPTH 2048
`define SNM_ADDR_ONE 11'h001
`define SNM_PROT_QUARTER 11'h600
`define SNM_PROT_HALF 11'h400
`define SNM_BP_NONE 2'h0
`define SNM_BP_QUARTER 2'h1
`define SNM_BP_HALF 2'h2

`define SNM_BIT_LAST 3'h7
`define SNM_BIT_ONE 3'h1
`define SNM_BIT_FIRST 3'h0

`define SNM_PIN_COUNT 5
`define SNM_PIN_CS 0
`define SNM_PIN_SCK 1
`define SNM_PIN_SI 2
`define SNM_PIN_PAUSE 3
`define SNM_PIN_WP 4
`define SNM_PIN_IDLE 5'h19

`endif

// [snm_spi_master.sv]
// SPI bus master model in mode 0 or mode 3
`timescale 1ns/1ps
`default_nettype none
module snm_spi_master (
  input wire logic clk, // Bench clock
  input wire logic so, // Resolved serial out
  output var logic cs_n, // Chip select
  output var logic sck, // Serial clock
  output var logic si, // Serial data in
  output var logic pause_n, // Pause pin
  output var logic wp_n // Protect pin
);
  int pause_bit = -1;
  // Idle clock level: low for mode 0, high for mode 3
  logic mode3 = 1'b0;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    pause_n = 1'b1;
    wp_n = 1'b1;
  end
  // Half of a 200 ns period, launched just after a clk edge
  task automatic half;
    repeat (4) @(posedge clk);
    #1;
  endtask : half
  task automatic set_wp(input logic v);
    wp_n = v;
  endtask : set_wp
  task automatic sel;
    sck = mode3;
    half();
    cs_n = 1'b0;
    half();
  endtask : sel
  task automatic desel;
    sck = mode3;
    half();
    cs_n = 1'b1;
    si = ~si;
    half();
    half();
  endtask : desel
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      si = tx[i];
      if (i == pause_bit) begin
        half();
        pause_n = 1'b0;
        repeat (2) begin
          half();
          sck = 1'b1;
          si = ~si;
          half();
          sck = 1'b0;
        end
        half();
        pause_n = 1'b1;
        si = tx[i];
      end
      half();
      sck = 1'b1;
      half();
      // Late in the high phase, once the output has settled
      rx[i] = so;
    end
  endtask : xfer
endmodule : snm_spi_master
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the protect controller
`timescale 1ns/1ps
`default_nettype none
`include "snm_regs.svh"
module tb_top import snm_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic so_data;
  logic so_oe_n;
  wire logic cs_n, sck, si, pause_pin_n, write_protect_pin_n, so;
  int n_errors = 0;
  int n_tests = 0;
  assign so = so_oe_n ? 1'bz : so_data;
  always #12.5 clk = ~clk;
  snm_spi_master m (.clk, .so, .cs_n, .sck, .si, .pause_n(pause_pin_n), .wp_n(write_protect_pin_n));
  snm_protect_ctrl uut (.clk, .rst, .ce, .cs_n, .sck, .si, .pause_pin_n, .write_protect_pin_n,
    .so_data, .so_oe_n);
  task automatic end_sim;
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cmd(logic [7:0] op);
    logic [7:0] r;
    m.sel();
    m.xfer(op, r);
    m.desel();
  endtask : cmd
  task automatic st_wr(logic [7:0] v);
    logic [7:0] r;
    cmd(`SNM_OP_SET_LATCH);
    m.sel();
    m.xfer(`SNM_OP_STATUS_WRITE, r);
    m.xfer(v, r);
    m.desel();
  endtask : st_wr
  task automatic st_chk(logic [7:0] exp);
    logic [7:0] r;
    m.sel();
    m.xfer(`SNM_OP_STATUS_READ, r);
    m.xfer(8'h00, r);
    m.desel();
    chk("status", exp, r);
  endtask : st_chk
  // Upper address bits are sent as ones; they must not matter
  task automatic frame(logic [7:0] op, snm_addr_type a, logic [7:0] d0, d1, output logic [7:0] q0, q1);
    logic [7:0] r;
    m.sel();
    m.xfer(op, r);
    m.xfer({5'h1f, a[10:8]}, r);
    m.xfer(a[7:0], r);
    m.xfer(d0, q0);
    m.xfer(d1, q1);
    m.desel();
  endtask : frame
  task automatic wr(snm_addr_type a, logic [7:0] d0, d1);
    logic [7:0] q0, q1;
    cmd(`SNM_OP_SET_LATCH);
    frame(`SNM_OP_MEM_WRITE, a, d0, d1, q0, q1);
  endtask : wr
  task automatic rd(snm_addr_type a, logic [7:0] e0, e1);
    logic [7:0] q0, q1;
    frame(`SNM_OP_MEM_READ, a, 8'hff, 8'h00, q0, q1);
    chk("read byte 0", e0, q0);
    chk("read byte 1", e1, q1);
  endtask : rd
  task automatic t_status;
    logic [7:0] r;
    st_chk(8'h00);
    cmd(`SNM_OP_SET_LATCH);
    st_chk(8'h02);
    cmd(`SNM_OP_CLEAR_LATCH);
    st_chk(8'h00);
    m.sel();
    m.xfer(8'h5a, r);
    m.xfer(`SNM_OP_SET_LATCH, r);
    m.desel();
    chk("unknown opcode out", 8'hzz, r);
    st_chk(8'h00);
    st_wr(8'hff);
    st_chk(8'h8c);
    m.set_wp(1'b0);
    st_wr(8'h00);
    st_chk(8'h8c);
    m.set_wp(1'b1);
    st_wr(8'h00);
    st_chk(8'h00);
  endtask : t_status
  task automatic t_mem;
    logic [7:0] q0, q1;
    wr(11'h3ff, 8'h10, 8'h11);
    wr(11'h5ff, 8'h20, 8'h21);
    wr(11'h7ff, 8'h30, 8'h31);
    st_chk(8'h00);
    rd(11'h7ff, 8'h30, 8'h31);
    frame(`SNM_OP_MEM_WRITE, 11'h7ff, 8'h55, 8'h55, q0, q1);
    rd(11'h7ff, 8'h30, 8'h31);
    rd(11'h3ff, 8'h10, 8'h11);
  endtask : t_mem
  task automatic t_protect;
    snm_addr_type base[3] = '{11'h5ff, 11'h3ff, 11'h7ff};
    logic [7:0] e0[3] = '{8'hf1, 8'hf2, 8'h30};
    logic [7:0] e1[3] = '{8'h21, 8'h11, 8'h31};
    for (int b = 1; b <= 3; b++) begin
      m.set_wp(1'b1);
      st_wr(8'hf3 | 8'(b << 2));
      m.set_wp(1'b0);
      wr(base[b-1], 8'hf0 | 8'(b), 8'he0 | 8'(b));
      rd(base[b-1], e0[b-1], e1[b-1]);
      st_wr(8'h00);
      st_chk(8'h80 | 8'(b << 2));
    end
  endtask : t_protect
  task automatic t_pause;
    m.set_wp(1'b1);
    st_wr(8'h00);
    m.pause_bit = 4;
    rd(11'h7ff, 8'h30, 8'h31);
    m.pause_bit = -1;
  endtask : t_pause
  // Same traffic with the clock idling high
  task automatic t_mode3;
    m.mode3 = 1'b1;
    rd(11'h7ff, 8'h30, 8'h31);
    wr(11'h100, 8'ha5, 8'h5a);
    rd(11'h100, 8'ha5, 8'h5a);
    st_chk(8'h00);
    m.mode3 = 1'b0;
  endtask : t_mode3
  // A command sent while the clock enable is low must leave no trace
  task automatic t_freeze;
    ce = 1'b0;
    cmd(`SNM_OP_SET_LATCH);
    ce = 1'b1;
    st_chk(8'h00);
    cmd(`SNM_OP_SET_LATCH);
    st_chk(8'h02);
    cmd(`SNM_OP_CLEAR_LATCH);
  endtask : t_freeze
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    t_status();
    t_mem();
    t_protect();
    t_pause();
    t_mode3();
    t_freeze();
    end_sim();
  end
  // Whole run needs well under half of this
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
